/* rtl/mfc_params.svh */
// Constants for the memory fill and compare engine: offsets, flag positions, codes.
`ifndef MFC_PARAMS_SVH
`define MFC_PARAMS_SVH
// ----------------------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------------------
`define MFC_OP_FILL 8'h04
`define MFC_OP_CMP 8'h05
// ----------------------------------------------------------------------------
// Descriptor bit positions (byte offset times eight)
// ----------------------------------------------------------------------------
`define MFC_DESC_W 512
`define MFC_D_FLAGS 32
`define MFC_D_OP 56
`define MFC_D_CRA 64
`define MFC_D_PATLO 128
`define MFC_D_SRC1 128
`define MFC_D_DST 192
`define MFC_D_SRC2 192
`define MFC_D_SIZE 256
`define MFC_D_PATHI 320
`define MFC_D_EXP 320
// ----------------------------------------------------------------------------
// Flag bits within the 24-bit flags field
// ----------------------------------------------------------------------------
`define MFC_F_PAT16 18
`define MFC_F_CHECK 7
`define MFC_F_FILL_RSVD 24'hfb0000
// ----------------------------------------------------------------------------
// Completion record bit positions and codes, then pattern byte index masks
// ----------------------------------------------------------------------------
`define MFC_CREC_W 128
`define MFC_R_STATUS 0
`define MFC_R_RESULT 8
`define MFC_R_FINFO 16
`define MFC_R_BYTES 32
`define MFC_R_FADDR 64
`define MFC_ST_SUCCESS 8'h01
`define MFC_ST_FALSE_PRED 8'h02
`define MFC_ST_PAGE_FAULT 8'h03
`define MFC_ST_BAD_FLAGS 8'h10
`define MFC_ST_BAD_OP 8'h11
`define MFC_FI_READ 8'h00
`define MFC_FI_WRITE 8'h01
`define MFC_PMASK8 4'h7
`define MFC_PMASK16 4'hf
`endif

/* rtl/mfc_pkg.sv */
// Types shared by the memory fill and compare engine.
package mfc_pkg;
   // -------------------------------------------------------------------------
   // Engine states, one-hot
   // -------------------------------------------------------------------------
   typedef enum logic [5:0] {
      st_idle = 6'h01,
      st_fill = 6'h02,
      st_rd1 = 6'h04,
      st_wt1 = 6'h08,
      st_rd2 = 6'h10,
      st_wt2 = 6'h20
   } mfc_state_t;
   // -------------------------------------------------------------------------
   // Write beat carried through the buffer
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [63:0] addr;
      logic [7:0] data;
   } mfc_wbeat_t;
endpackage

/* rtl/mfc_buf.sv */
// Small FIFO that decouples the fill byte stream from the memory write port.
`timescale 1ns/1ps
module mfc_buf #(
   parameter int W = 72,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin : g_bad
         $error("mfc_buf: DEPTH must be a power of two of at least 2");
      end
   endgenerate

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp, rp, next_wp, next_rp;
   logic [AW:0] cnt, next_cnt;
   logic push, pop;

   assign in_ready = ce && (cnt != (AW+1)'(DEPTH));
   assign out_valid = ce && (cnt != '0);
   assign out_data = mem[rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_wp = wp;
      next_rp = rp;
      next_cnt = cnt;
      if (flush) begin
         next_wp = '0;
         next_rp = '0;
         next_cnt = '0;
      end else begin
         if (push) begin
            next_wp = wp + 1'b1;
         end
         if (pop) begin
            next_rp = rp + 1'b1;
         end
         next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else if (ce) begin
         wp <= next_wp;
         rp <= next_rp;
         cnt <= next_cnt;
      end
   end

   // Storage carries no reset; occupancy alone says what is valid.
   always_ff @(posedge clk) begin
      if (ce && push && !flush) begin
         mem[wp] <= in_data;
      end
   end
endmodule

/* rtl/mfc_engine.sv */
// Fill and compare execution engine with completion record output.
`timescale 1ns/1ps
`include "mfc_params.svh"

// Functional notes
// - Fill opcode writes pattern repeatedly, exactly transfer-size bytes.
// - Pattern flag clear: 8-byte lower pattern; set: lower then upper bytes.
// - Fill length need not be pattern multiple; last copy truncated.
// - Fill works at any destination alignment and any length.
// - Fill page fault reports destination bytes written before fault.
// - Compare opcode compares transfer-size bytes of source1 and source2, unaligned.
// - Compare result zero when identical, one on any difference.
// - On mismatch, bytes completed is offset of first difference.
// - Compare fault reports result zero; earlier mismatch wins over fault.
// - Check flag set: success when result equals expected, else false predicate.
// - Only bit zero of expected-result byte is used.
// - False predicate from compare is held for later fenced descriptors.
module mfc_engine #(
   parameter int BUF_DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic desc_valid,
   output logic desc_ready,
   input wire logic [`MFC_DESC_W-1:0] desc,
   input wire logic wide_pattern_fill_capability,
   input wire logic batch_start,
   output logic batch_pred_false,
   output logic wr_valid,
   input wire logic wr_ready,
   input wire logic wr_fault,
   output mfc_pkg::mfc_wbeat_t wr_beat,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [63:0] rd_addr,
   input wire logic rd_rsp_valid,
   input wire logic rd_rsp_fault,
   input wire logic [7:0] rd_rsp_data,
   output logic cr_valid,
   input wire logic cr_ready,
   output logic [63:0] cr_addr,
   output logic [`MFC_CREC_W-1:0] cr_data
);
   generate
      if (BUF_DEPTH < 2) begin : g_bad
         $error("mfc_engine: BUF_DEPTH must be at least 2");
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Record packing and compare status
   // -------------------------------------------------------------------------
   function automatic logic [`MFC_CREC_W-1:0] pack_rec(input logic [7:0] st,
         input logic [7:0] res, input logic [7:0] fi, input logic [31:0] nb,
         input logic [63:0] fa);
      logic [`MFC_CREC_W-1:0] r;
      r = '0;
      r[`MFC_R_STATUS +: 8] = st;
      r[`MFC_R_RESULT +: 8] = res;
      r[`MFC_R_FINFO +: 8] = fi;
      r[`MFC_R_BYTES +: 32] = nb;
      r[`MFC_R_FADDR +: 64] = fa;
      return r;
   endfunction

   function automatic logic [7:0] cmp_status(input logic res, input logic chk,
         input logic exp_bit);
      if (chk && (res != exp_bit)) begin
         return `MFC_ST_FALSE_PRED;
      end
      return `MFC_ST_SUCCESS;
   endfunction

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   mfc_pkg::mfc_state_t state, next_state;
   logic [63:0] base, next_base, src2, next_src2, next_rd_addr, next_cr_addr;
   logic [127:0] pat, next_pat;
   logic [31:0] size, next_size, idx, next_idx, done_cnt, next_done_cnt;
   logic pat16, next_pat16, chk, next_chk, exp_bit, next_exp_bit;
   logic [7:0] b1, next_b1;
   logic rec, next_rec, next_pred;
   logic [`MFC_CREC_W-1:0] next_cr_data;

   logic [23:0] d_flags;
   logic [7:0] d_op;
   logic [31:0] d_size;
   logic [3:0] pidx;
   logic push_valid, push_ready, flush, wr_take;
   mfc_pkg::mfc_wbeat_t push_beat;

   assign d_flags = desc[`MFC_D_FLAGS +: 24];
   assign d_op = desc[`MFC_D_OP +: 8];
   assign d_size = desc[`MFC_D_SIZE +: 32];
   assign desc_ready = ce && (state == mfc_pkg::st_idle) && !rec;
   assign cr_valid = ce && rec;
   assign rd_valid = ce && (state == mfc_pkg::st_rd1 || state == mfc_pkg::st_rd2);
   assign wr_take = wr_valid && wr_ready;

   // pattern byte index wraps at 8 or 16 bytes; truncates naturally
   assign pidx = idx[3:0] & (pat16 ? `MFC_PMASK16 : `MFC_PMASK8);
   // byte-wise stream: any address and length
   assign push_valid = (state == mfc_pkg::st_fill) && (idx != size);
   assign push_beat.addr = base + 64'(idx);
   assign push_beat.data = pat[{pidx, 3'h0} +: 8];
   assign flush = (state == mfc_pkg::st_fill) && wr_take && wr_fault;

   mfc_buf #(
      .W($bits(mfc_pkg::mfc_wbeat_t)),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .flush(flush),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_beat),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(wr_beat)
   );

   // -------------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_base = base;
      next_src2 = src2;
      next_pat = pat;
      next_size = size;
      next_idx = idx;
      next_done_cnt = done_cnt;
      next_pat16 = pat16;
      next_chk = chk;
      next_exp_bit = exp_bit;
      next_b1 = b1;
      next_rec = rec;
      next_rd_addr = rd_addr;
      next_cr_addr = cr_addr;
      next_cr_data = cr_data;
      next_pred = batch_pred_false;
      // a new batch clears the held predicate
      if (batch_start) begin
         next_pred = 1'b0;
      end
      if (cr_valid && cr_ready) begin
         next_rec = 1'b0;
      end
      case (state)
         mfc_pkg::st_idle: begin
            if (desc_valid && desc_ready) begin
               next_cr_addr = desc[`MFC_D_CRA +: 64];
               next_size = d_size;
               next_idx = '0;
               next_done_cnt = '0;
               // fill fields at their descriptor offsets
               next_pat = {desc[`MFC_D_PATHI +: 64], desc[`MFC_D_PATLO +: 64]};
               next_base = (d_op == `MFC_OP_FILL) ? desc[`MFC_D_DST +: 64] :
                                                    desc[`MFC_D_SRC1 +: 64];
               next_src2 = desc[`MFC_D_SRC2 +: 64];
               next_pat16 = d_flags[`MFC_F_PAT16];
               next_chk = d_flags[`MFC_F_CHECK];
               // only the low bit of expected result
               next_exp_bit = desc[`MFC_D_EXP];
               next_rd_addr = desc[`MFC_D_SRC1 +: 64];
               if (d_op == `MFC_OP_FILL) begin
                  // refuse reserved flags or unsupported wide pattern
                  if ((d_flags & `MFC_F_FILL_RSVD) != '0 ||
                      (d_flags[`MFC_F_PAT16] && !wide_pattern_fill_capability)) begin
                     next_cr_data = pack_rec(`MFC_ST_BAD_FLAGS, 8'h00, 8'h00, 32'h0, 64'h0);
                     next_rec = 1'b1;
                  end else begin
                     next_state = mfc_pkg::st_fill;
                  end
               end else if (d_op == `MFC_OP_CMP) begin
                  if (d_size == '0) begin
                     next_cr_data = pack_rec(cmp_status(1'b0, d_flags[`MFC_F_CHECK],
                        desc[`MFC_D_EXP]), 8'h00, 8'h00, 32'h0, 64'h0);
                     next_pred = next_pred || (d_flags[`MFC_F_CHECK] && desc[`MFC_D_EXP]);
                     next_rec = 1'b1;
                  end else begin
                     next_state = mfc_pkg::st_rd1;
                  end
               end else begin
                  next_cr_data = pack_rec(`MFC_ST_BAD_OP, 8'h00, 8'h00, 32'h0, 64'h0);
                  next_rec = 1'b1;
               end
            end
         end
         mfc_pkg::st_fill: begin
            if (push_valid && push_ready) begin
               next_idx = idx + 32'h1;
            end
            if (flush) begin
               // report bytes accepted before the faulting write
               next_cr_data = pack_rec(`MFC_ST_PAGE_FAULT, 8'h00, `MFC_FI_WRITE, done_cnt,
                                       wr_beat.addr);
               next_rec = 1'b1;
               next_state = mfc_pkg::st_idle;
            end else if (wr_take) begin
               next_done_cnt = done_cnt + 32'h1;
            end else if (done_cnt == size) begin
               // done after exactly transfer-size bytes written
               next_cr_data = pack_rec(`MFC_ST_SUCCESS, 8'h00, 8'h00, size, 64'h0);
               next_rec = 1'b1;
               next_state = mfc_pkg::st_idle;
            end
         end
         mfc_pkg::st_rd1, mfc_pkg::st_rd2: begin
            if (rd_ready && ce) begin
               next_state = (state == mfc_pkg::st_rd1) ? mfc_pkg::st_wt1 : mfc_pkg::st_wt2;
            end
         end
         mfc_pkg::st_wt1, mfc_pkg::st_wt2: begin
            if (rd_rsp_valid) begin
               if (rd_rsp_fault) begin
                  // fault with no difference seen reports result zero
                  next_cr_data = pack_rec(`MFC_ST_PAGE_FAULT, 8'h00, `MFC_FI_READ, idx,
                                          rd_addr);
                  next_rec = 1'b1;
                  next_state = mfc_pkg::st_idle;
               end else if (state == mfc_pkg::st_wt1) begin
                  next_b1 = rd_rsp_data;
                  next_rd_addr = src2 + 64'(idx);
                  next_state = mfc_pkg::st_rd2;
               end else if (rd_rsp_data != b1) begin
                  // result one; bytes completed is this offset
                  next_cr_data = pack_rec(cmp_status(1'b1, chk, exp_bit), 8'h01, 8'h00, idx,
                                          64'h0);
                  next_pred = next_pred || (chk && !exp_bit);
                  next_rec = 1'b1;
                  next_state = mfc_pkg::st_idle;
               end else if (idx + 32'h1 == size) begin
                  next_cr_data = pack_rec(cmp_status(1'b0, chk, exp_bit), 8'h00, 8'h00,
                                          32'h0, 64'h0);
                  next_pred = next_pred || (chk && exp_bit);
                  next_rec = 1'b1;
                  next_state = mfc_pkg::st_idle;
               end else begin
                  next_idx = idx + 32'h1;
                  next_rd_addr = base + 64'(idx + 32'h1);
                  next_state = mfc_pkg::st_rd1;
               end
            end
         end
         default: begin
            next_state = mfc_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= mfc_pkg::st_idle;
         base <= '0;
         src2 <= '0;
         pat <= '0;
         size <= '0;
         idx <= '0;
         done_cnt <= '0;
         pat16 <= 1'b0;
         chk <= 1'b0;
         exp_bit <= 1'b0;
         b1 <= '0;
         rec <= 1'b0;
         rd_addr <= '0;
         cr_addr <= '0;
         cr_data <= '0;
         batch_pred_false <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         base <= next_base;
         src2 <= next_src2;
         pat <= next_pat;
         size <= next_size;
         idx <= next_idx;
         done_cnt <= next_done_cnt;
         pat16 <= next_pat16;
         chk <= next_chk;
         exp_bit <= next_exp_bit;
         b1 <= next_b1;
         rec <= next_rec;
         rd_addr <= next_rd_addr;
         cr_addr <= next_cr_addr;
         cr_data <= next_cr_data;
         batch_pred_false <= next_pred;
      end
   end

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   a_fill_bound: assert property (@(posedge clk) disable iff (rst)
      (state == mfc_pkg::st_fill && wr_take) |-> (wr_beat.addr - base) < 64'(size))
      else $error("fill write outside destination region");
   a_fill_done: assert property (@(posedge clk) disable iff (rst)
      (ce && state == mfc_pkg::st_fill && !wr_take && done_cnt == size) |=>
      (rec && cr_data[`MFC_R_BYTES +: 32] == $past(size) &&
       cr_data[`MFC_R_STATUS +: 8] == `MFC_ST_SUCCESS))
      else $error("fill did not finish with full byte count");
   a_fill_fault: assert property (@(posedge clk) disable iff (rst)
      (ce && flush) |=> (rec && cr_data[`MFC_R_BYTES +: 32] == $past(done_cnt) &&
       cr_data[`MFC_R_FADDR +: 64] == $past(wr_beat.addr)))
      else $error("fill fault record wrong");
   a_bad_flags: assert property (@(posedge clk) disable iff (rst)
      (desc_valid && desc_ready && d_op == `MFC_OP_FILL &&
       (d_flags & `MFC_F_FILL_RSVD) != '0) |=>
      (state == mfc_pkg::st_idle && rec && cr_data[`MFC_R_STATUS +: 8] == `MFC_ST_BAD_FLAGS))
      else $error("reserved fill flags not refused");
   a_pat_width: assert property (@(posedge clk) disable iff (rst)
      (push_valid && !pat16) |-> push_beat.data == pat[{1'b0, idx[2:0], 3'h0} +: 8])
      else $error("narrow pattern used upper bytes");
   a_cmp_addr: assert property (@(posedge clk) disable iff (rst)
      (rd_valid && state == mfc_pkg::st_rd2) |-> rd_addr == src2 + 64'(idx))
      else $error("second source address wrong");
   a_cmp_miss: assert property (@(posedge clk) disable iff (rst)
      (ce && state == mfc_pkg::st_wt2 && rd_rsp_valid && !rd_rsp_fault && rd_rsp_data != b1)
      |=> (rec && cr_data[`MFC_R_RESULT +: 8] == 8'h01 &&
           cr_data[`MFC_R_BYTES +: 32] == $past(idx)))
      else $error("mismatch offset or result wrong");
   a_cmp_fault: assert property (@(posedge clk) disable iff (rst)
      (ce && (state == mfc_pkg::st_wt1 || state == mfc_pkg::st_wt2) && rd_rsp_valid &&
       rd_rsp_fault) |=> (cr_data[`MFC_R_RESULT +: 8] == 8'h00 &&
       cr_data[`MFC_R_STATUS +: 8] == `MFC_ST_PAGE_FAULT))
      else $error("compare fault record wrong");
   a_pred_hold: assert property (@(posedge clk) disable iff (rst)
      (ce && !rec && next_rec && next_cr_data[`MFC_R_STATUS +: 8] == `MFC_ST_FALSE_PRED)
      |=> batch_pred_false ##1 (batch_pred_false || $past(batch_start)))
      else $error("false predicate not held");
endmodule

/* bench/mfc_mem_model.sv */
// Host memory model serving the engine's write and read ports.
`timescale 1ns/1ps
module mfc_mem_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic fault_en,
   input wire logic [7:0] fault_addr,
   input wire logic wr_valid,
   output logic wr_ready,
   output logic wr_fault,
   input wire mfc_pkg::mfc_wbeat_t wr_beat,
   input wire logic rd_valid,
   output logic rd_ready,
   input wire logic [63:0] rd_addr,
   output logic rd_rsp_valid = 1'b0,
   output logic rd_rsp_fault = 1'b0,
   output logic [7:0] rd_rsp_data = 8'h00
);
   logic [7:0] mem [256];
   logic busy = 1'b0;
   logic tog = 1'b0;
   logic [1:0] cnt = 2'h0;
   logic [7:0] ra = 8'h00;
   int wcount = 0;
   // Only the low address byte decodes, so every test region sits below 0x100.
   assign wr_ready = !slow || tog;
   assign wr_fault = fault_en && wr_beat.addr[7:0] == fault_addr;
   assign rd_ready = !busy;
   always @(posedge clk) begin
      tog <= !tog;
      rd_rsp_valid <= 1'b0;
      rd_rsp_fault <= 1'b0;
      // Data is inverted when idle so a stale byte cannot pass as an answer.
      rd_rsp_data <= ~rd_rsp_data;
      if (wr_valid && wr_ready && !wr_fault) begin
         mem[wr_beat.addr[7:0]] <= wr_beat.data;
         wcount <= wcount + 1;
      end
      if (rst) begin
         busy <= 1'b0;
      end else if (busy) begin
         cnt <= cnt - 2'h1;
         if (cnt == 2'h0) begin
            busy <= 1'b0;
            rd_rsp_valid <= 1'b1;
            rd_rsp_data <= mem[ra];
            rd_rsp_fault <= fault_en && ra == fault_addr;
         end
      end else if (rd_valid) begin
         busy <= 1'b1;
         ra <= rd_addr[7:0];
         cnt <= slow ? 2'h3 : 2'h0;
      end
   end
endmodule

/* bench/tb.sv */
// Self-checking bench for the fill and compare engine.
`timescale 1ns/1ps
`include "mfc_params.svh"
module tb;
   localparam logic [63:0] PLO = 64'h0706050403020100;
   localparam logic [63:0] PHI = 64'h0f0e0d0c0b0a0908;
   // Record-address-valid and record-request flag bits; the engine ignores them.
   localparam logic [23:0] CR_FLAGS = 24'h00000c;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic desc_valid = 1'b0;
   logic [511:0] desc = '0;
   logic cap = 1'b0;
   logic batch_start = 1'b0;
   logic cr_ready = 1'b0;
   logic slow = 1'b0;
   logic fault_en = 1'b0;
   logic [7:0] fault_addr = 8'h00;
   logic desc_ready, batch_pred_false, wr_valid, wr_ready, wr_fault, rd_valid, rd_ready;
   logic rd_rsp_valid, rd_rsp_fault, cr_valid;
   logic [7:0] rd_rsp_data;
   logic [63:0] rd_addr, cr_addr, rec_addr;
   logic [127:0] cr_data, rec;
   mfc_pkg::mfc_wbeat_t wr_beat;
   int fails = 0;
   int n_tests = 0;
   mfc_engine #(.BUF_DEPTH(2)) uut (.clk(clk), .rst(rst), .ce(1'b1), .desc_valid(desc_valid),
      .desc_ready(desc_ready), .desc(desc), .wide_pattern_fill_capability(cap),
      .batch_start(batch_start), .batch_pred_false(batch_pred_false), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_fault(wr_fault), .wr_beat(wr_beat), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_addr(rd_addr), .rd_rsp_valid(rd_rsp_valid),
      .rd_rsp_fault(rd_rsp_fault), .rd_rsp_data(rd_rsp_data), .cr_valid(cr_valid),
      .cr_ready(cr_ready), .cr_addr(cr_addr), .cr_data(cr_data));
   mfc_mem_model m (.clk(clk), .rst(rst), .slow(slow), .fault_en(fault_en),
      .fault_addr(fault_addr), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_fault(wr_fault),
      .wr_beat(wr_beat), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_addr(rd_addr),
      .rd_rsp_valid(rd_rsp_valid), .rd_rsp_fault(rd_rsp_fault), .rd_rsp_data(rd_rsp_data));
   initial begin
      forever #2 clk = ~clk;
   end
   // ----------
   // Shared tasks
   // ----------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [511:0] mk(input logic [7:0] op, input logic [23:0] fl,
         input logic [63:0] a16, input logic [63:0] a24, input logic [31:0] n,
         input logic [63:0] a40);
      mk = '0;
      mk[63:56] = op;
      mk[55:32] = fl;
      mk[127:64] = 64'h1000;
      mk[191:128] = a16;
      mk[255:192] = a24;
      mk[287:256] = n;
      mk[383:320] = a40;
   endfunction
   task automatic run(input logic [511:0] d);
      int i;
      @(negedge clk);
      desc = d;
      desc_valid = 1'b1;
      for (i = 0; i < 100 && !desc_ready; i++) @(negedge clk);
      @(negedge clk);
      desc_valid = 1'b0;
      for (i = 0; i < 2000 && !cr_valid; i++) @(negedge clk);
      chk(64'(cr_valid), 64'h1);
      rec = cr_data;
      rec_addr = cr_addr;
      cr_ready = 1'b1;
      @(negedge clk);
      cr_ready = 1'b0;
   endtask
   // ----------
   // Scenarios
   // ----------
   task automatic t_fill(input logic wide, input int n, input logic [7:0] dst);
      for (int k = 0; k < 64; k++) m.mem[8'h20 + 8'(k)] = 8'hee;
      cap = wide;
      run(mk(`MFC_OP_FILL, {5'h00, wide, 18'h0}, PLO, {56'h0, dst}, 32'(n), PHI));
      chk(rec[7:0], `MFC_ST_SUCCESS);
      chk(rec[63:32], 64'(n));
      chk(rec_addr, 64'h1000);
      for (int k = 0; k <= n; k++)
         chk(m.mem[dst + 8'(k)], k < n ? 8'(k % (wide ? 16 : 8)) : 8'hee);
      $display("test fill wide=%0d size=%0d done", wide, n);
   endtask
   task automatic t_bad();
      logic [23:0] fl [3] = '{24'h010000, 24'h080000, 24'h040000};
      int w0;
      cap = 1'b0;
      for (int i = 0; i < 3; i++) begin
         w0 = m.wcount;
         run(mk(`MFC_OP_FILL, fl[i], PLO, 64'h20, 32'd4, PHI));
         chk(rec[7:0], `MFC_ST_BAD_FLAGS);
         chk(64'(m.wcount - w0), 64'h0);
      end
      w0 = m.wcount;
      run(mk(8'h03, 24'h0, PLO, 64'h20, 32'd4, PHI));
      chk(rec[7:0], `MFC_ST_BAD_OP);
      chk(64'(m.wcount - w0), 64'h0);
      $display("test bad flags done");
   endtask
   task automatic t_ffault();
      fault_en = 1'b1;
      fault_addr = 8'h25;
      run(mk(`MFC_OP_FILL, 24'h0, PLO, 64'h20, 32'd10, PHI));
      fault_en = 1'b0;
      chk(rec[7:0], `MFC_ST_PAGE_FAULT);
      chk(rec[63:32], 64'd5);
      chk(rec[23:16], `MFC_FI_WRITE);
      chk(rec[127:64], 64'h25);
      $display("test fill fault done");
   endtask
   // A df or nb below zero means no differing byte, or bytes completed left unchecked.
   task automatic cmp(input int n, input int df, input logic [23:0] fl, input logic [7:0] eb,
         input logic [7:0] fa, input logic [7:0] st, input logic [7:0] res, input int nb);
      for (int i = 0; i < 16; i++) begin
         m.mem[8'h80 + 8'(i)] = 8'(i * 7);
         m.mem[8'ha0 + 8'(i)] = 8'(i * 7) ^ (i == df ? 8'h10 : 8'h00);
      end
      fault_en = fa != 8'h00;
      fault_addr = fa;
      // record flags set, record address valid
      run(mk(`MFC_OP_CMP, fl | CR_FLAGS, 64'h80, 64'ha0, 32'(n), {56'h0, eb}));
      fault_en = 1'b0;
      chk(rec[7:0], st);
      chk(rec[15:8], res);
      if (nb >= 0) chk(rec[63:32], 64'(nb));
   endtask
   task automatic t_cmp();
      slow = 1'b1;
      cmp(6, -1, 24'h0, 8'h00, 8'h00, `MFC_ST_SUCCESS, 8'h00, -1);
      cmp(6, 3, 24'h0, 8'h00, 8'h00, `MFC_ST_SUCCESS, 8'h01, 3);
      slow = 1'b0;
      cmp(5, 0, 24'h0, 8'h01, 8'h00, `MFC_ST_SUCCESS, 8'h01, 0);
      cmp(4, -1, 24'h80, 8'hfe, 8'h00, `MFC_ST_SUCCESS, 8'h00, -1);
      chk(batch_pred_false, 64'h0);
      cmp(4, -1, 24'h80, 8'h01, 8'h00, `MFC_ST_FALSE_PRED, 8'h00, -1);
      chk(batch_pred_false, 64'h1);
      cmp(4, 2, 24'h80, 8'hff, 8'h00, `MFC_ST_SUCCESS, 8'h01, 2);
      chk(batch_pred_false, 64'h1);
      batch_start = 1'b1;
      @(negedge clk);
      batch_start = 1'b0;
      chk(batch_pred_false, 64'h0);
      cmp(4, 2, 24'h80, 8'h00, 8'h00, `MFC_ST_FALSE_PRED, 8'h01, 2);
      cmp(0, -1, 24'h0, 8'h00, 8'h00, `MFC_ST_SUCCESS, 8'h00, 0);
      chk(batch_pred_false, 64'h1);
      $display("test compare done");
   endtask
   task automatic t_cfault();
      cmp(6, -1, 24'h0, 8'h00, 8'ha2, `MFC_ST_PAGE_FAULT, 8'h00, 2);
      chk(rec[23:16], `MFC_FI_READ);
      chk(rec[127:64], 64'ha2);
      cmp(6, 1, 24'h0, 8'h00, 8'ha2, `MFC_ST_SUCCESS, 8'h01, 1);
      $display("test compare fault done");
   endtask
   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      slow = 1'b1;
      t_fill(1'b0, 19, 8'h23);
      slow = 1'b0;
      t_fill(1'b1, 21, 8'h21);
      t_bad();
      t_ffault();
      t_cmp();
      t_cfault();
      end_sim();
   end
   // The tests need a few hundred cycles; this bound leaves wide margin.
   initial begin
      #100000;
      fails++;
      end_sim();
   end
endmodule
